// >>> rtl/mcic_ctrl.sv
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module mcic_ctrl
  import mcic_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST_N,
  input  wire logic              CLK_EN,
  input  wire logic [1:0]        REG_ADDR,
  input  wire logic [DATA_W-1:0] REG_WDATA,
  input  wire logic              REG_WR,
  input  wire logic              REG_RD,
  output var  logic [DATA_W-1:0] REG_RDATA,
  input  wire logic [3:0]        UPPER_FLAG_PINS_I,
  output var  logic [3:0]        UPPER_FLAG_PINS_O,
  output var  logic [3:0]        UPPER_FLAG_PINS_OE,
  input  wire logic              SP1_SHARED_REQUEST_TX_N,
  input  wire logic              SP1_SHARED_REQUEST_RX_N,
  input  wire logic              SPA_TX_EVT,
  input  wire logic              SPA_RX_EVT,
  input  wire logic              SPB_TX_EVT,
  input  wire logic              SPB_RX_EVT,
  input  wire logic              BYTE_DMA_EVT,
  input  wire logic              TIMER_EVT,
  input  wire logic              PWRUP_WAKE,
  input  wire logic              IRQ_ACK,
  output var  logic              IRQ_REQ,
  output var  logic [3:0]        IRQ_SRC,
  output var  logic [VEC_W-1:0]  IRQ_VEC
);

  if (DATA_W < SRC_N) begin : g_bad_width
    $error("DATA_W must hold all twelve source bits");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_lvl;
  logic [PIN_N-1:0] pin_fall;

  // pins read back the resolved wire, so a flag driven low by us counts
  assign pin_raw = {SP1_SHARED_REQUEST_RX_N, SP1_SHARED_REQUEST_TX_N,
                    UPPER_FLAG_PINS_I};

  mcic_sync_edge #(
    .W (PIN_N)
  ) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .din   (pin_raw),
    .level (pin_lvl),
    .fall  (pin_fall)
  );

  // pin order: [3] general, [2] level hi, [1] level lo, [0] edge
  wire gen_low    = !pin_lvl[3];
  wire lvl_hi_low = !pin_lvl[2];
  wire lvl_lo_low = !pin_lvl[1];
  wire shr_tx_low = !pin_lvl[4];
  wire shr_rx_low = !pin_lvl[5];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [SRC_N-1:0]  mask_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [3:0]        flag_out_q;
  logic [3:0]        flag_oe_q;
  logic [SRC_N-1:0]  latch_q;
  logic [SRC_N-1:0]  latch_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  mcic_irq_s         irq_q;
  mcic_irq_s         irq_d;

  wire wr_mask = REG_WR && (REG_ADDR == REG_MASK);
  wire wr_ctrl = REG_WR && (REG_ADDR == REG_CTRL);
  wire wr_pend = REG_WR && (REG_ADDR == REG_PEND);
  wire wr_flag = REG_WR && (REG_ADDR == REG_FLAG);

  wire gie       = ctrl_q[CTRL_GIE];
  wire sense_gen = ctrl_q[CTRL_SENSE_GEN];
  wire sense_tx  = ctrl_q[CTRL_SENSE_TX];
  wire sense_rx  = ctrl_q[CTRL_SENSE_RX];
  wire spb_sel   = ctrl_q[CTRL_SPB_SEL];
  wire puctx     = ctrl_q[CTRL_PUCTX];

  // force bit is a strobe, it is never stored
  wire pd_force = wr_ctrl && REG_WDATA[CTRL_PD_FORCE];

  // ----------------------------------------------------------------
  // request sources
  // ----------------------------------------------------------------
  logic [SRC_N-1:0] set_vec;
  logic [SRC_N-1:0] lvl_term;
  logic [SRC_N-1:0] req_raw;
  logic [SRC_N-1:0] enable_vec;
  logic [SRC_N-1:0] eligible;
  logic [SRC_N-1:0] clr_vec;
  logic [SRC_N-1:0] sw_force;

  // software may pend any maskable source by writing the pending word
  assign sw_force = wr_pend ? (REG_WDATA[SRC_N-1:0] & MASKABLE)
                            : '0;

  assign set_vec[SRC_RESET]  = PWRUP_WAKE && puctx;
  assign set_vec[SRC_PWRDN]  = pd_force;
  assign set_vec[SRC_GEN]    = sense_gen && pin_fall[3];
  assign set_vec[SRC_LVL_HI] = 1'b0;
  assign set_vec[SRC_LVL_LO] = 1'b0;
  assign set_vec[SRC_SPA_TX] = SPA_TX_EVT;
  assign set_vec[SRC_SPA_RX] = SPA_RX_EVT;
  assign set_vec[SRC_EDGE]   = pin_fall[0];
  assign set_vec[SRC_BYTE_DMA_PORT]   = BYTE_DMA_EVT;
  assign set_vec[SRC_SHR_TX] = spb_sel ? SPB_TX_EVT
                                       : (sense_tx && pin_fall[4]);
  assign set_vec[SRC_SHR_RX] = spb_sel ? SPB_RX_EVT
                                       : (sense_rx && pin_fall[5]);
  assign set_vec[SRC_TIMER]  = TIMER_EVT;

  // level terms are live while the pin is held low, never latched
  assign lvl_term = {1'b0,
                     !spb_sel && !sense_rx && shr_rx_low,
                     !spb_sel && !sense_tx && shr_tx_low,
                     4'h0,
                     lvl_lo_low,
                     lvl_hi_low,
                     !sense_gen && gen_low,
                     2'h0};

  assign req_raw    = latch_q | lvl_term;
  assign enable_vec = (gie ? (mask_q & MASKABLE) : '0) | ~MASKABLE;

  wire ack_fire = IRQ_ACK && irq_q.req;

  assign clr_vec  = ack_fire ? (SRC_N'(1) << irq_q.src) : '0;
  // the source just taken is hidden for one cycle while its latch drops
  assign eligible = req_raw & enable_vec & ~clr_vec;
  // a new event in the clearing cycle survives the clear
  assign latch_d  = (latch_q & ~clr_vec) | set_vec | sw_force;

  // ----------------------------------------------------------------
  // priority selection
  // ----------------------------------------------------------------
  function automatic logic [3:0] first_set(input logic [SRC_N-1:0] v);
    first_set = SRC_TIMER;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  wire [3:0] win_src = first_set(eligible);

  assign irq_d.req = |eligible;
  assign irq_d.src = irq_d.req ? win_src : 4'h0;
  assign irq_d.vec = irq_d.req ? mcic_vec_of(win_src) : VEC_RESET;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = '0;
    case (REG_ADDR)
      REG_MASK: rd_word[SRC_N-1:0] = mask_q;
      REG_CTRL: rd_word[CTRL_W-1:0] = ctrl_q;
      REG_PEND: rd_word[SRC_N-1:0] = req_raw;
      REG_FLAG: rd_word[11:0] = {pin_lvl[3:0], flag_oe_q, flag_out_q};
      default:  rd_word = '0;
    endcase
  end

  // data stands in the cycle after the strobe only
  assign rdata_d = REG_RD ? rd_word : '0;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_q <= MASK_RST;
      ctrl_q <= CTRL_RST;
    end else if (CLK_EN) begin
      if (wr_mask) begin
        mask_q <= REG_WDATA[SRC_N-1:0] & MASKABLE;
      end
      if (wr_ctrl) begin
        ctrl_q <= REG_WDATA[CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flag_out_q <= FLAG_RST;
      flag_oe_q  <= FLAG_RST;
    end else if (CLK_EN && wr_flag) begin
      flag_out_q <= REG_WDATA[3:0];
      flag_oe_q  <= REG_WDATA[7:4];
    end
  end

  // reset pends the reset vector, taken first after release
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      latch_q <= LATCH_RST;
      irq_q   <= '0;
      rdata_q <= '0;
    end else if (CLK_EN) begin
      latch_q <= latch_d;
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA          = rdata_q;
  assign UPPER_FLAG_PINS_O  = flag_out_q;
  assign UPPER_FLAG_PINS_OE = flag_oe_q;
  assign IRQ_REQ            = irq_q.req;
  assign IRQ_SRC            = irq_q.src;
  assign IRQ_VEC            = irq_q.vec;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_take_latched;
    CLK_EN && ack_fire && !set_vec[irq_q.src] && !sw_force[irq_q.src];
  endsequence

  sequence s_edge_pin_fall;
    CLK_EN && pin_fall[0];
  endsequence

  chk_reset_vec_first: assert property (
    CLK_EN && latch_q[SRC_RESET] && !ack_fire
      |=> irq_q.req && irq_q.vec == VEC_RESET)
    else $error("pending reset did not win with vector zero");

  chk_pwrdn_nomask: assert property (
    CLK_EN && latch_q[SRC_PWRDN] && !latch_q[SRC_RESET] && !ack_fire
      |=> irq_q.req && irq_q.vec == VEC_PWRDN)
    else $error("power-down request blocked or misvectored");

  chk_disabled_quiet: assert property (
    CLK_EN && !gie && !latch_q[SRC_RESET] && !latch_q[SRC_PWRDN]
      |=> !irq_q.req)
    else $error("maskable request served while disabled");

  chk_latch_clears: assert property (
    s_take_latched |=> !latch_q[$past(irq_q.src)])
    else $error("latched request not cleared at service");

  chk_set_wins: assert property (
    CLK_EN && set_vec[SRC_TIMER] |=> latch_q[SRC_TIMER])
    else $error("event lost in clearing cycle");

  chk_edge_latch: assert property (
    s_edge_pin_fall |=> latch_q[SRC_EDGE])
    else $error("edge request fall not latched");

  chk_level_live: assert property (
    CLK_EN && lvl_hi_low && gie && mask_q[SRC_LVL_HI] && !ack_fire
      && !(|req_raw[2:0]) |=> irq_q.req && irq_q.src == SRC_LVL_HI)
    else $error("level request high not served while held low");

  chk_prio_order: assert property (
    CLK_EN && eligible[SRC_GEN] |=> irq_q.src <= SRC_GEN)
    else $error("lower priority source beat general request");

  chk_vector_map: assert property (
    irq_q.req |-> irq_q.vec == mcic_vec_of(irq_q.src))
    else $error("vector does not match source");

  chk_shared_route: assert property (
    CLK_EN && spb_sel && SPB_RX_EVT |=> latch_q[SRC_SHR_RX])
    else $error("serial port b receive not routed to shared vector");

  // a take in the cycle after the latch hides the source for one cycle
  chk_force_pwrdn: assert property (
    CLK_EN && pd_force |=> latch_q[SRC_PWRDN] ##1 (!CLK_EN
      || latch_q[SRC_RESET] || $past(ack_fire) || IRQ_VEC == VEC_PWRDN))
    else $error("power-down force did not raise its interrupt");

endmodule

`default_nettype wire

// >>> rtl/mcic_pkg.sv
package mcic_pkg;

  // ----------------------------------------------------------------
  // sources, in priority order (index 0 is serviced first)
  // ----------------------------------------------------------------
  localparam int SRC_N = 12;
  localparam int VEC_W = 14;
  localparam int PIN_N = 6;

  localparam logic [3:0] SRC_RESET  = 4'h0;
  localparam logic [3:0] SRC_PWRDN  = 4'h1;
  localparam logic [3:0] SRC_GEN    = 4'h2;
  localparam logic [3:0] SRC_LVL_HI = 4'h3;
  localparam logic [3:0] SRC_LVL_LO = 4'h4;
  localparam logic [3:0] SRC_SPA_TX = 4'h5;
  localparam logic [3:0] SRC_SPA_RX = 4'h6;
  localparam logic [3:0] SRC_EDGE   = 4'h7;
  localparam logic [3:0] SRC_BYTE_DMA_PORT   = 4'h8;
  localparam logic [3:0] SRC_SHR_TX = 4'h9;
  localparam logic [3:0] SRC_SHR_RX = 4'hA;
  localparam logic [3:0] SRC_TIMER  = 4'hB;

  localparam logic [VEC_W-1:0] VEC_RESET  = 14'h0000;
  localparam logic [VEC_W-1:0] VEC_PWRDN  = 14'h002C;
  localparam logic [VEC_W-1:0] VEC_GEN    = 14'h0004;
  localparam logic [VEC_W-1:0] VEC_LVL_HI = 14'h0008;
  localparam logic [VEC_W-1:0] VEC_LVL_LO = 14'h000C;
  localparam logic [VEC_W-1:0] VEC_SPA_TX = 14'h0010;
  localparam logic [VEC_W-1:0] VEC_SPA_RX = 14'h0014;
  localparam logic [VEC_W-1:0] VEC_EDGE   = 14'h0018;
  localparam logic [VEC_W-1:0] VEC_BYTE_DMA_PORT   = 14'h001C;
  localparam logic [VEC_W-1:0] VEC_SHR_TX = 14'h0020;
  localparam logic [VEC_W-1:0] VEC_SHR_RX = 14'h0024;
  localparam logic [VEC_W-1:0] VEC_TIMER  = 14'h0028;

  // ----------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_MASK = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_PEND = 2'h2;
  localparam logic [1:0] REG_FLAG = 2'h3;

  localparam int CTRL_GIE       = 0;
  localparam int CTRL_SENSE_GEN = 1;
  localparam int CTRL_SENSE_TX  = 2;
  localparam int CTRL_SENSE_RX  = 3;
  localparam int CTRL_SPB_SEL   = 4;
  localparam int CTRL_PUCTX     = 5;
  localparam int CTRL_PD_FORCE  = 6;
  localparam int CTRL_W         = 6;

  localparam logic [SRC_N-1:0]  MASKABLE   = 12'hFFC;
  localparam logic [SRC_N-1:0]  MASK_RST   = 12'h000;
  localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h00;
  localparam logic [SRC_N-1:0]  LATCH_RST  = 12'h001;
  localparam logic [3:0]        FLAG_RST   = 4'h0;

  // ----------------------------------------------------------------
  // carrier for the vector request towards the sequencer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             req;
    logic [3:0]       src;
    logic [VEC_W-1:0] vec;
  } mcic_irq_s;

  function automatic logic [VEC_W-1:0] mcic_vec_of(input logic [3:0] s);
    case (s)
      SRC_RESET:  mcic_vec_of = VEC_RESET;
      SRC_PWRDN:  mcic_vec_of = VEC_PWRDN;
      SRC_GEN:    mcic_vec_of = VEC_GEN;
      SRC_LVL_HI: mcic_vec_of = VEC_LVL_HI;
      SRC_LVL_LO: mcic_vec_of = VEC_LVL_LO;
      SRC_SPA_TX: mcic_vec_of = VEC_SPA_TX;
      SRC_SPA_RX: mcic_vec_of = VEC_SPA_RX;
      SRC_EDGE:   mcic_vec_of = VEC_EDGE;
      SRC_BYTE_DMA_PORT:   mcic_vec_of = VEC_BYTE_DMA_PORT;
      SRC_SHR_TX: mcic_vec_of = VEC_SHR_TX;
      SRC_SHR_RX: mcic_vec_of = VEC_SHR_RX;
      default:    mcic_vec_of = VEC_TIMER;
    endcase
  endfunction

endpackage

// >>> rtl/mcic_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

module mcic_sync_edge #(
  parameter int W = 6
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] level,
  output var  logic [W-1:0] fall
);

  // idle pins are high, so every stage resets high to avoid a false fall
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else if (ce) begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign fall  = s3_q & ~s2_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_fall_seen(int i);
    ce && fall[i];
  endsequence

  for (genvar g = 0; g < W; g++) begin : g_chk
    chk_fall_single: assert property (
      s_fall_seen(g) ##1 ce |-> !fall[g])
      else $error("falling edge reported on two cycles");
  end

endmodule

`default_nettype wire

// >>> verif/mcic_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// external parties on the request pins
// ----------------------------------------------------------------
module mcic_pin_model (
  input  wire logic [3:0] ext_low,
  input  wire logic [1:0] shr_low,
  input  wire logic [3:0] pin_o,
  input  wire logic [3:0] pin_oe,
  output var  logic [3:0] pin_lvl,
  output var  logic       shr_tx_n,
  output var  logic       shr_rx_n
);
  // pulled-up wires: a released pin floats high, any low driver wins
  always_comb begin
    pin_lvl  = ~((pin_oe & ~pin_o) | ext_low);
    shr_tx_n = ~shr_low[1];
    shr_rx_n = ~shr_low[0];
  end
endmodule

`default_nettype wire

// >>> verif/tb_modem_core_interrupt_controller.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("Error %s exp %h got %h", nm, e, g); \
  end \
end

module tb_modem_core_interrupt_controller
  import mcic_pkg::*;
;
  logic             sys_clk = 1'b0;
  logic             rst_n   = 1'b0;
  logic             reg_wr  = 1'b0;
  logic             reg_rd  = 1'b0;
  logic             ack     = 1'b0;
  logic             wake    = 1'b0;
  logic [1:0]       addr    = 2'h0;
  logic [15:0]      wdata   = 16'h0000;
  logic [5:0]       evt     = 6'h00;
  logic [3:0]       ext_low = 4'h0;
  logic [1:0]       shr_low = 2'h0;
  wire logic [15:0] rdata;
  wire logic [3:0]  pin_lvl;
  wire logic [3:0]  flag_o;
  wire logic [3:0]  flag_oe;
  wire logic        shr_tx_n;
  wire logic        shr_rx_n;
  wire logic        irq_req;
  wire logic [3:0]  irq_src;
  wire logic [VEC_W-1:0] irq_vec;
  int               n_fail   = 0;
  int               compares = 0;
  int               cyc      = 0;
  logic [VEC_W-1:0] vtab [SRC_N] = '{VEC_RESET, VEC_PWRDN, VEC_GEN,
    VEC_LVL_HI, VEC_LVL_LO, VEC_SPA_TX, VEC_SPA_RX, VEC_EDGE, VEC_BYTE_DMA_PORT,
    VEC_SHR_TX, VEC_SHR_RX, VEC_TIMER};
  logic [3:0]       ord [6] = '{SRC_SPA_TX, SRC_SPA_RX, SRC_BYTE_DMA_PORT,
    SRC_SHR_TX, SRC_SHR_RX, SRC_TIMER};

  mcic_ctrl i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(1'b1),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(rdata), .UPPER_FLAG_PINS_I(pin_lvl),
    .UPPER_FLAG_PINS_O(flag_o), .UPPER_FLAG_PINS_OE(flag_oe),
    .SP1_SHARED_REQUEST_TX_N(shr_tx_n),
    .SP1_SHARED_REQUEST_RX_N(shr_rx_n), .SPA_TX_EVT(evt[5]),
    .SPA_RX_EVT(evt[4]), .SPB_TX_EVT(evt[3]), .SPB_RX_EVT(evt[2]),
    .BYTE_DMA_EVT(evt[1]), .TIMER_EVT(evt[0]), .PWRUP_WAKE(wake),
    .IRQ_ACK(ack), .IRQ_REQ(irq_req), .IRQ_SRC(irq_src),
    .IRQ_VEC(irq_vec));

  mcic_pin_model i_pins (.ext_low(ext_low), .shr_low(shr_low),
    .pin_o(flag_o), .pin_oe(flag_oe), .pin_lvl(pin_lvl),
    .shr_tx_n(shr_tx_n), .shr_rx_n(shr_rx_n));

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // bus and sequencer tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // read data stand in this cycle only, take them mid-cycle
    @(negedge sys_clk);
    d = rdata;
  endtask

  // pin requests need sync cycles, so wait bounded rather than fixed
  task automatic svc(input logic [3:0] s);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (irq_req !== 1'b1 && k < 40);
    `CHK("irq_req", 1'b1, irq_req)
    `CHK("irq_src", s, irq_src)
    `CHK("irq_vec", vtab[s], irq_vec)
    @(posedge sys_clk);
    ack <= 1'b1;
    @(posedge sys_clk);
    ack <= 1'b0;
  endtask

  task automatic idle();
    repeat (8) @(negedge sys_clk);
    `CHK("irq_req", 1'b0, irq_req)
    `CHK("irq_vec", 14'h0000, irq_vec)
  endtask

  task automatic ev(input logic [5:0] v);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= 6'h00;
  endtask

  task automatic pins(input logic [3:0] p, input logic [1:0] s);
    @(posedge sys_clk);
    ext_low <= p;
    shr_low <= s;
    // let the synchronisers settle so an old level cannot win
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic pw();
    @(posedge sys_clk);
    wake <= 1'b1;
    @(posedge sys_clk);
    wake <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      $display("Error cycles exp 4999 got 5000");
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] d;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    svc(SRC_RESET);
    rd(REG_MASK, d);
    `CHK("mask", 16'h0000, d)
    rd(REG_CTRL, d);
    `CHK("ctrl", 16'h0000, d)
    wr(REG_MASK, 16'h0FFC);
    ev(6'h01);
    idle();
    wr(REG_CTRL, 16'h0001);
    svc(SRC_TIMER);
    wr(REG_MASK, 16'h0000);
    ev(6'h01);
    idle();
    wr(REG_MASK, 16'h0FFC);
    svc(SRC_TIMER);
    wr(REG_CTRL, 16'h0040);
    svc(SRC_PWRDN);
    rd(REG_CTRL, d);
    `CHK("ctrl", 16'h0000, d)
    $display("test enable and mask done");
    wr(REG_CTRL, 16'h0011);
    wr(REG_PEND, 16'h0FFC);
    rd(REG_PEND, d);
    `CHK("pend", 16'h0FFC, d)
    for (int i = 2; i < SRC_N; i++) svc(i[3:0]);
    idle();
    ev(6'h3F);
    foreach (ord[j]) svc(ord[j]);
    idle();
    $display("test priority done");
    wr(REG_CTRL, 16'h0001);
    pins(4'h1, 2'h0);
    pins(4'h0, 2'h0);
    svc(SRC_EDGE);
    idle();
    pins(4'h4, 2'h0);
    svc(SRC_LVL_HI);
    svc(SRC_LVL_HI);
    pins(4'h2, 2'h0);
    svc(SRC_LVL_LO);
    pins(4'h0, 2'h0);
    idle();
    wr(REG_FLAG, 16'h0080);
    @(negedge sys_clk);
    `CHK("flag_oe", 4'h8, flag_oe)
    `CHK("flag_o", 4'h0, flag_o)
    svc(SRC_GEN);
    // pin 3 reads back low while we drive it, the others float high
    rd(REG_FLAG, d);
    `CHK("flag", 16'h0780, d)
    wr(REG_FLAG, 16'h0000);
    idle();
    $display("test pins done");
    pins(4'h0, 2'h2);
    svc(SRC_SHR_TX);
    svc(SRC_SHR_TX);
    pins(4'h0, 2'h0);
    idle();
    // held low in edge mode must be taken once only
    wr(REG_CTRL, 16'h000F);
    pins(4'h8, 2'h3);
    svc(SRC_GEN);
    svc(SRC_SHR_TX);
    svc(SRC_SHR_RX);
    idle();
    pins(4'h0, 2'h0);
    wr(REG_CTRL, 16'h0001);
    pw();
    idle();
    wr(REG_CTRL, 16'h0021);
    pw();
    svc(SRC_RESET);
    // a reset in mid-run must drop the enable and pend the reset vector
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    svc(SRC_RESET);
    rd(REG_CTRL, d);
    `CHK("ctrl", 16'h0000, d)
    rd(REG_MASK, d);
    `CHK("mask", 16'h0000, d)
    $display("test shared and wake done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
